//--- hdl/pbt_pkg.sv
// Package for the self-test, clock delay and line-driver trim register bank.
// Assumes a 16-bit register port with 8-bit addresses; all logic on one core clock.
package pbt_pkg;

    // Register offsets
    localparam logic [7:0]  PBT_OFS_PKT_LEN   = 8'h7b;
    localparam logic [7:0]  PBT_OFS_GAP_LEN   = 8'h7c;
    localparam logic [7:0]  PBT_OFS_CLK_DELAY = 8'h86;
    localparam logic [7:0]  PBT_OFS_RX_EQ     = 8'h8a;
    localparam logic [7:0]  PBT_OFS_GAIN_AB   = 8'ha0;
    localparam logic [7:0]  PBT_OFS_GAIN_CD   = 8'ha1;
    localparam logic [7:0]  PBT_OFS_SWING_AB  = 8'ha2;
    localparam logic [7:0]  PBT_OFS_ST_CTRL   = 8'hf0;
    localparam logic [7:0]  PBT_OFS_ST_STATUS = 8'hf1;

    // Reset values
    localparam logic [15:0] PBT_PKT_LEN_RST   = 16'h05dc;
    localparam logic [7:0]  PBT_GAP_LEN_RST   = 8'h7d;
    localparam logic [15:0] PBT_RX_EQ_RST     = 16'h0000;
    localparam logic [3:0]  PBT_DELAY_RST     = 4'h7;
    localparam logic [3:0]  PBT_GAIN_RST      = 4'h8;
    localparam logic [4:0]  PBT_SWING_A_RST   = 5'h10;
    localparam logic [4:0]  PBT_SWING_B_RST   = 5'h08;
    localparam logic [4:0]  PBT_SWING_DEFAULT = 5'h10;

    // Field positions
    localparam int PBT_DLY_TX_LSB   = 4;
    localparam int PBT_DLY_RX_LSB   = 0;
    localparam int PBT_HI_FIELD_LSB = 8;
    localparam int PBT_LO_FIELD_LSB = 0;
    localparam int PBT_SW_EN_B_BIT  = 13;
    localparam int PBT_SW_EN_A_BIT  = 5;
    localparam int PBT_ST_EN_BIT    = 0;

    // Self-test frame shape
    localparam logic [17:0] PBT_PRE_NIBBLES = 18'd13;
    localparam logic [3:0]  PBT_PRE_NIBBLE  = 4'h5;
    localparam logic [7:0]  PBT_SFD_BYTE    = 8'hd5;
    localparam logic [17:0] PBT_SFD_NIBBLES = 18'd2;
    localparam logic [1:0]  PBT_GAP_SHIFT   = 2'd2;

    typedef enum logic [2:0] {
        PBT_IDLE = 3'b000,
        PBT_PRE  = 3'b001,
        PBT_SFD  = 3'b010,
        PBT_DATA = 3'b011,
        PBT_GAP  = 3'b100
    } pbt_gen_state_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } pbt_bus_req_t;

    typedef struct packed {
        logic        enable;
        logic [15:0] pkt_bytes;
        logic [7:0]  gap_units;
    } pbt_gen_cfg_t;

    typedef struct packed {
        logic       valid;
        logic [3:0] data;
    } pbt_nib_t;

    // Bytes to nibble count
    function automatic logic [17:0] pbt_byte_nibs(input logic [16:0] bytes);
        pbt_byte_nibs = {bytes, 1'b0};
    endfunction

    // Gap units to gap bytes, four bytes per unit
    function automatic logic [16:0] pbt_gap_bytes(input logic [7:0] units);
        pbt_gap_bytes = 17'(units) << PBT_GAP_SHIFT;
    endfunction

endpackage

//--- hdl/pbt_selftest_gen.sv
// Self-test packet generator: nibble stream of preamble, delimiter, payload, gap.
// Assumes a synchronised active-low reset; length and gap are latched at each packet start, enable is used live.
`timescale 1ns/1ps
`default_nettype none
module pbt_selftest_gen
    import pbt_pkg::*;
(
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire pbt_gen_cfg_t cfg_i,
    output var  pbt_nib_t     nib_o,
    output logic              active_o,
    output logic              pkt_done_o
);
    pbt_gen_state_t state_reg, state_next;
    logic [17:0]    cnt_reg, cnt_next;
    logic [15:0]    len_reg;
    logic [7:0]     gap_reg;
    pbt_nib_t       nib_reg, nib_next;
    logic [17:0]    limit;
    logic           last;
    pbt_gen_state_t gap_exit, after_data, after_sfd;
    logic           start;

    assign limit = (state_reg == PBT_PRE)  ? PBT_PRE_NIBBLES :
                   (state_reg == PBT_SFD)  ? PBT_SFD_NIBBLES :
                   (state_reg == PBT_DATA) ? pbt_byte_nibs({1'b0, len_reg}) :
                   pbt_byte_nibs(pbt_gap_bytes(gap_reg));
    assign last       = (cnt_reg == limit - 18'd1);
    // Disabling stops cleanly only at a packet boundary
    assign gap_exit   = cfg_i.enable ? PBT_PRE : PBT_IDLE;
    assign after_data = (gap_reg == 8'h00) ? gap_exit : PBT_GAP;
    assign after_sfd  = (len_reg == 16'h0000) ? after_data : PBT_DATA;
    assign start      = (state_next == PBT_PRE) && (state_reg != PBT_PRE);

    always_comb
    begin
        state_next = state_reg;
        cnt_next   = cnt_reg + 18'd1;
        unique case (state_reg)
            PBT_IDLE:
            begin
                cnt_next = '0;
                if (cfg_i.enable)
                    state_next = PBT_PRE;
            end
            PBT_PRE:  if (last) state_next = PBT_SFD;
            PBT_SFD:  if (last) state_next = after_sfd;
            PBT_DATA: if (last) state_next = after_data;
            PBT_GAP:  if (last) state_next = gap_exit;
            default:  state_next = PBT_IDLE;
        endcase
        if (state_reg != PBT_IDLE && last)
            cnt_next = '0;
    end

    always_comb
    begin
        nib_next.valid = (state_reg == PBT_PRE) || (state_reg == PBT_SFD) || (state_reg == PBT_DATA);
        nib_next.data  = 4'h0;
        if (state_reg == PBT_PRE)
            nib_next.data = PBT_PRE_NIBBLE;
        else if (state_reg == PBT_SFD)
            nib_next.data = cnt_reg[0] ? PBT_SFD_BYTE[7:4] : PBT_SFD_BYTE[3:0];
        else if (state_reg == PBT_DATA)
            nib_next.data = cnt_reg[0] ? cnt_reg[8:5] : cnt_reg[4:1];
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_reg <= PBT_IDLE;
            cnt_reg   <= '0;
            len_reg   <= PBT_PKT_LEN_RST;
            gap_reg   <= PBT_GAP_LEN_RST;
            nib_reg   <= '0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            nib_reg   <= nib_next;
            if (start)
            begin
                len_reg <= cfg_i.pkt_bytes;
                gap_reg <= cfg_i.gap_units;
            end
        end
    end

    assign nib_o      = nib_reg;
    assign active_o   = (state_reg != PBT_IDLE);
    assign pkt_done_o = last && ((state_reg == PBT_DATA) || (state_reg == PBT_SFD && len_reg == 16'h0000));

    a_pre_length: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (state_reg == PBT_PRE && state_next == PBT_SFD) |-> cnt_reg == 18'd12)
        else $error("preamble not 13 nibbles");
    a_sfd_nibbles: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (state_reg == PBT_SFD && cnt_reg == 18'd0) |=> nib_o.data == 4'h5 ##1 nib_o.data == 4'hd)
        else $error("delimiter nibbles wrong");
    a_gap_span: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (state_reg == PBT_GAP && state_next != PBT_GAP) |-> cnt_reg == 18'(gap_reg) * 18'd8 - 18'd1)
        else $error("gap not four bytes per unit");

endmodule // pbt_selftest_gen
`default_nettype wire

//--- hdl/phy_bist_delay_trim_regs.sv
// Register bank: self-test packet shape, interface clock delays, equalizer word,
// line-driver fine gain and swing overrides. Plain register port, read data one cycle later.
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// - 16-bit packet length field, resets to 1500 bytes, sets self-test packet size.
// - Each self-test packet carries 13 nibbles of 0x5 then delimiter byte 0xD5.
// - 8-bit gap field, resets to 0x7D meaning 500 bytes.
// - Each gap unit adds four bytes of idle between packets.
// - 16-bit equalizer word resets to zero; software may write 0x010F.
// - Transmit delay in bits 7:4, 0.25 ns per step from 0.25 ns.
// - Receive delay in bits 3:0, same encoding as transmit.
// - Delays load from straps on one variant, else reset to 0111; writable.
// - Upper byte of the delay register ignores writes and reads zero.
// - Fine gain fields reset to trim, 2 percent steps, 1000 is unity.
// - Channels B and D in bits 11:8, A and C in bits 3:0.
// - Channel A swing bits 4:0, reset 10000, applies only while its override set.
// - Channel B override at bit 13 resets 0; swing bits 12:8 apply when set.
module phy_bist_delay_trim_regs
    import pbt_pkg::*;
(
    input  wire logic        CLK_I,
    input  wire logic        RST_N_I,
    input  wire logic [7:0]  BUS_ADDR_I,
    input  wire logic [15:0] BUS_WDATA_I,
    input  wire logic        BUS_WR_I,
    input  wire logic        BUS_RD_I,
    output logic [15:0]      BUS_RDATA_O,
    input  wire logic        STRAP_VARIANT_I,
    input  wire logic [3:0]  STRAP_TX_DELAY_I,
    input  wire logic [3:0]  STRAP_RX_DELAY_I,
    input  wire logic [15:0] TRIM_FINE_GAIN_I,
    output logic [3:0]       TX_DELAY_CODE_O,
    output logic [3:0]       RX_DELAY_CODE_O,
    output logic [15:0]      RX_EQ_WORD_O,
    output logic [15:0]      FINE_GAIN_O,
    output logic [4:0]       SWING_CHAN_A_O,
    output logic [4:0]       SWING_CHAN_B_O,
    output logic [3:0]       SELFTEST_NIB_O,
    output logic             SELFTEST_VALID_O
);
    logic         rst_meta_reg;
    logic         rst_n;
    pbt_bus_req_t bus;
    logic         wr_len, wr_gap, wr_dly, wr_eq, wr_fg_ab, wr_fg_cd, wr_sw, wr_ctrl;
    logic [15:0]  pkt_len_reg;
    logic [7:0]   gap_units_reg;
    logic [3:0]   tx_dly_reg, rx_dly_reg;
    logic [15:0]  rx_eq_reg;
    logic [3:0]   gain_a_reg, gain_b_reg, gain_c_reg, gain_d_reg;
    logic [4:0]   swing_a_reg, swing_b_reg;
    logic         sw_en_a_reg, sw_en_b_reg;
    logic         st_enable_reg;
    logic         load_done_reg;
    logic [7:0]   pkt_cnt_reg;
    logic [15:0]  rdata_reg, rdata_next;
    logic [4:0]   swing_a_out_reg, swing_b_out_reg;
    logic [15:0]  dly_word, fg_ab_word, fg_cd_word, sw_word, status_word;
    logic         mapped;
    pbt_gen_cfg_t gen_cfg;
    pbt_nib_t     gen_nib;
    logic         gen_active, gen_pkt_done;

    // Reset released through two flops; asserts asynchronously
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            rst_meta_reg <= 1'b0;
            rst_n        <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_n        <= rst_meta_reg;
        end
    end

    assign bus = '{wr: BUS_WR_I, rd: BUS_RD_I, addr: BUS_ADDR_I, wdata: BUS_WDATA_I};

    assign wr_len   = bus.wr && (bus.addr == PBT_OFS_PKT_LEN);
    assign wr_gap   = bus.wr && (bus.addr == PBT_OFS_GAP_LEN);
    assign wr_dly   = bus.wr && (bus.addr == PBT_OFS_CLK_DELAY);
    assign wr_eq    = bus.wr && (bus.addr == PBT_OFS_RX_EQ);
    assign wr_fg_ab = bus.wr && (bus.addr == PBT_OFS_GAIN_AB);
    assign wr_fg_cd = bus.wr && (bus.addr == PBT_OFS_GAIN_CD);
    assign wr_sw    = bus.wr && (bus.addr == PBT_OFS_SWING_AB);
    assign wr_ctrl  = bus.wr && (bus.addr == PBT_OFS_ST_CTRL);

    // Read views; reserved bits are constant zero
    assign dly_word    = {8'h00, tx_dly_reg, rx_dly_reg};
    assign fg_ab_word  = {4'h0, gain_b_reg, 4'h0, gain_a_reg};
    assign fg_cd_word  = {4'h0, gain_d_reg, 4'h0, gain_c_reg};
    assign sw_word     = {2'b00, sw_en_b_reg, swing_b_reg, 2'b00, sw_en_a_reg, swing_a_reg};
    assign status_word = {pkt_cnt_reg, 7'h00, gen_active};

    assign mapped = (bus.addr == PBT_OFS_PKT_LEN) || (bus.addr == PBT_OFS_GAP_LEN) ||
                    (bus.addr == PBT_OFS_CLK_DELAY) || (bus.addr == PBT_OFS_RX_EQ) ||
                    (bus.addr == PBT_OFS_GAIN_AB) || (bus.addr == PBT_OFS_GAIN_CD) ||
                    (bus.addr == PBT_OFS_SWING_AB) || (bus.addr == PBT_OFS_ST_CTRL) ||
                    (bus.addr == PBT_OFS_ST_STATUS);

    assign rdata_next = !(bus.rd && mapped)               ? 16'h0000 :
                        (bus.addr == PBT_OFS_PKT_LEN)   ? pkt_len_reg :
                        (bus.addr == PBT_OFS_GAP_LEN)   ? {8'h00, gap_units_reg} :
                        (bus.addr == PBT_OFS_CLK_DELAY) ? dly_word :
                        (bus.addr == PBT_OFS_RX_EQ)     ? rx_eq_reg :
                        (bus.addr == PBT_OFS_GAIN_AB)   ? fg_ab_word :
                        (bus.addr == PBT_OFS_GAIN_CD)   ? fg_cd_word :
                        (bus.addr == PBT_OFS_SWING_AB)  ? sw_word :
                        (bus.addr == PBT_OFS_ST_CTRL)   ? {15'h0000, st_enable_reg} :
                        status_word;

    // Self-test shape and equalizer
    always_ff @(posedge CLK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pkt_len_reg   <= PBT_PKT_LEN_RST;
            gap_units_reg <= PBT_GAP_LEN_RST;
            rx_eq_reg     <= PBT_RX_EQ_RST;
            st_enable_reg <= 1'b0;
        end
        else
        begin
            if (wr_len)
                pkt_len_reg <= bus.wdata;
            if (wr_gap)
                gap_units_reg <= bus.wdata[7:0];
            if (wr_eq)
                rx_eq_reg <= bus.wdata;
            if (wr_ctrl)
                st_enable_reg <= bus.wdata[PBT_ST_EN_BIT];
        end
    end

    // Straps and trim are caught in the first cycle after reset release, never by the reset itself.
    // A write landing in that very cycle to these fields is lost.
    always_ff @(posedge CLK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            load_done_reg <= 1'b0;
            tx_dly_reg    <= PBT_DELAY_RST;
            rx_dly_reg    <= PBT_DELAY_RST;
            gain_a_reg    <= PBT_GAIN_RST;
            gain_b_reg    <= PBT_GAIN_RST;
            gain_c_reg    <= PBT_GAIN_RST;
            gain_d_reg    <= PBT_GAIN_RST;
        end
        else if (!load_done_reg)
        begin
            load_done_reg <= 1'b1;
            gain_a_reg    <= TRIM_FINE_GAIN_I[3:0];
            gain_b_reg    <= TRIM_FINE_GAIN_I[7:4];
            gain_c_reg    <= TRIM_FINE_GAIN_I[11:8];
            gain_d_reg    <= TRIM_FINE_GAIN_I[15:12];
            if (STRAP_VARIANT_I)
            begin
                tx_dly_reg <= STRAP_TX_DELAY_I;
                rx_dly_reg <= STRAP_RX_DELAY_I;
            end
        end
        else
        begin
            if (wr_dly)
            begin
                tx_dly_reg <= bus.wdata[PBT_DLY_TX_LSB +: 4];
                rx_dly_reg <= bus.wdata[PBT_DLY_RX_LSB +: 4];
            end
            if (wr_fg_ab)
            begin
                gain_b_reg <= bus.wdata[PBT_HI_FIELD_LSB +: 4];
                gain_a_reg <= bus.wdata[PBT_LO_FIELD_LSB +: 4];
            end
            if (wr_fg_cd)
            begin
                gain_d_reg <= bus.wdata[PBT_HI_FIELD_LSB +: 4];
                gain_c_reg <= bus.wdata[PBT_LO_FIELD_LSB +: 4];
            end
        end
    end

    // Swing overrides and the effective swing driven to the line drivers
    always_ff @(posedge CLK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            swing_a_reg     <= PBT_SWING_A_RST;
            swing_b_reg     <= PBT_SWING_B_RST;
            sw_en_a_reg     <= 1'b0;
            sw_en_b_reg     <= 1'b0;
            swing_a_out_reg <= PBT_SWING_DEFAULT;
            swing_b_out_reg <= PBT_SWING_DEFAULT;
        end
        else
        begin
            if (wr_sw)
            begin
                swing_b_reg <= bus.wdata[PBT_HI_FIELD_LSB +: 5];
                sw_en_b_reg <= bus.wdata[PBT_SW_EN_B_BIT];
                swing_a_reg <= bus.wdata[PBT_LO_FIELD_LSB +: 5];
                sw_en_a_reg <= bus.wdata[PBT_SW_EN_A_BIT];
            end
            swing_a_out_reg <= sw_en_a_reg ? swing_a_reg : PBT_SWING_DEFAULT;
            swing_b_out_reg <= sw_en_b_reg ? swing_b_reg : PBT_SWING_DEFAULT;
        end
    end

    always_ff @(posedge CLK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata_reg   <= 16'h0000;
            pkt_cnt_reg <= 8'h00;
        end
        else
        begin
            rdata_reg <= rdata_next;
            if (gen_pkt_done)
                pkt_cnt_reg <= pkt_cnt_reg + 8'h01;
        end
    end

    assign gen_cfg = '{enable: st_enable_reg, pkt_bytes: pkt_len_reg, gap_units: gap_units_reg};

    pbt_selftest_gen u_gen (
        .clk_i      (CLK_I),
        .rst_n_i    (rst_n),
        .cfg_i      (gen_cfg),
        .nib_o      (gen_nib),
        .active_o   (gen_active),
        .pkt_done_o (gen_pkt_done)
    );

    assign BUS_RDATA_O      = rdata_reg;
    assign TX_DELAY_CODE_O  = tx_dly_reg;
    assign RX_DELAY_CODE_O  = rx_dly_reg;
    assign RX_EQ_WORD_O     = rx_eq_reg;
    assign FINE_GAIN_O      = {gain_d_reg, gain_c_reg, gain_b_reg, gain_a_reg};
    assign SWING_CHAN_A_O   = swing_a_out_reg;
    assign SWING_CHAN_B_O   = swing_b_out_reg;
    assign SELFTEST_NIB_O   = gen_nib.data;
    assign SELFTEST_VALID_O = gen_nib.valid;

    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!rst_n);

    a_len_write: assert property (wr_len |=> pkt_len_reg == $past(BUS_WDATA_I))
        else $error("packet length write lost");
    a_gap_readback: assert property (bus.rd && bus.addr == PBT_OFS_GAP_LEN |=>
        BUS_RDATA_O == {8'h00, gap_units_reg})
        else $error("gap read wrong");
    a_eq_write: assert property (wr_eq && load_done_reg |=> RX_EQ_WORD_O == $past(BUS_WDATA_I))
        else $error("equalizer write lost");
    a_tx_delay: assert property (wr_dly && load_done_reg |=> TX_DELAY_CODE_O == $past(BUS_WDATA_I[7:4]))
        else $error("tx delay not from bits 7:4");
    a_rx_delay: assert property (wr_dly && load_done_reg |=> RX_DELAY_CODE_O == $past(BUS_WDATA_I[3:0]))
        else $error("rx delay not from bits 3:0");
    // Capture checks look at the sampled internal reset so the release edge itself never arms them
    a_strap_load: assert property (rst_n && !load_done_reg && STRAP_VARIANT_I |=>
        TX_DELAY_CODE_O == $past(STRAP_TX_DELAY_I) && RX_DELAY_CODE_O == $past(STRAP_RX_DELAY_I))
        else $error("straps not loaded");
    a_dly_upper_zero: assert property (bus.rd && bus.addr == PBT_OFS_CLK_DELAY |=>
        BUS_RDATA_O[15:8] == 8'h00)
        else $error("delay upper byte not zero");
    a_gain_lanes: assert property (wr_fg_ab && load_done_reg |=>
        FINE_GAIN_O[7:4] == $past(BUS_WDATA_I[11:8]) && FINE_GAIN_O[3:0] == $past(BUS_WDATA_I[3:0]))
        else $error("gain lanes wrong");
    a_swing_a: assert property (wr_sw |=> ##1
        SWING_CHAN_A_O == ($past(BUS_WDATA_I[5], 2) ? $past(BUS_WDATA_I[4:0], 2) : PBT_SWING_DEFAULT))
        else $error("channel A swing wrong");
    a_swing_b: assert property (wr_sw |=> ##1
        SWING_CHAN_B_O == ($past(BUS_WDATA_I[13], 2) ? $past(BUS_WDATA_I[12:8], 2) : PBT_SWING_DEFAULT))
        else $error("channel B swing wrong");
    a_fg_reserved: assert property (bus.rd && bus.addr == PBT_OFS_GAIN_CD |=>
        BUS_RDATA_O[15:12] == 4'h0 && BUS_RDATA_O[7:4] == 4'h0)
        else $error("reserved gain bits not zero");
    a_trim_load: assert property (rst_n && !load_done_reg |=>
        FINE_GAIN_O == $past(TRIM_FINE_GAIN_I))
        else $error("fine gain trim not loaded");
    a_delay_default: assert property (rst_n && !load_done_reg && !STRAP_VARIANT_I |=>
        TX_DELAY_CODE_O == PBT_DELAY_RST && RX_DELAY_CODE_O == PBT_DELAY_RST)
        else $error("delay default not kept");
    a_gain_cd_lanes: assert property (wr_fg_cd && load_done_reg |=>
        FINE_GAIN_O[15:12] == $past(BUS_WDATA_I[11:8]) && FINE_GAIN_O[11:8] == $past(BUS_WDATA_I[3:0]))
        else $error("gain lanes C D wrong");
    a_len_readback: assert property (bus.rd && bus.addr == PBT_OFS_PKT_LEN |=>
        BUS_RDATA_O == pkt_len_reg)
        else $error("packet length read wrong");
    a_eq_readback: assert property (bus.rd && bus.addr == PBT_OFS_RX_EQ |=>
        BUS_RDATA_O == RX_EQ_WORD_O)
        else $error("equalizer read wrong");
    a_unmapped_zero: assert property (bus.rd && !mapped |=>
        BUS_RDATA_O == 16'h0000)
        else $error("unmapped read not zero");

endmodule // phy_bist_delay_trim_regs
`default_nettype wire

//--- sim/testbench.sv
// Self-checking bench for the trim register bank: reset values, field masks, outputs, self-test stream.
// Assumes reads answer one cycle after the strobe and the bank never stalls the bus.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import pbt_pkg::*;
    logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, variant = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [15:0] wdata = 16'h0000, trim = 16'h0000, rdata, eq, gain;
    logic [3:0]  stx = 4'h2, srx = 4'hc, tx_dly, rx_dly, nib;
    logic [4:0]  sw_a, sw_b;
    logic        nvalid;
    logic [15:0] model [0:255];
    logic [15:0] mask [0:255];
    logic [7:0]  ofs [0:6] = '{8'h7b, 8'h7c, 8'h86, 8'h8a, 8'ha0, 8'ha1, 8'ha2};
    int          fail_count = 0, n_checks = 0, cycles = 0, seed = 32'ha647;
    int          q[$];

    phy_bist_delay_trim_regs uut (.CLK_I(clk), .RST_N_I(rst_n), .BUS_ADDR_I(addr), .BUS_WDATA_I(wdata),
        .BUS_WR_I(wr), .BUS_RD_I(rd), .BUS_RDATA_O(rdata), .STRAP_VARIANT_I(variant),
        .STRAP_TX_DELAY_I(stx), .STRAP_RX_DELAY_I(srx), .TRIM_FINE_GAIN_I(trim),
        .TX_DELAY_CODE_O(tx_dly), .RX_DELAY_CODE_O(rx_dly), .RX_EQ_WORD_O(eq), .FINE_GAIN_O(gain),
        .SWING_CHAN_A_O(sw_a), .SWING_CHAN_B_O(sw_b), .SELFTEST_NIB_O(nib), .SELFTEST_VALID_O(nvalid));

    always #12.5 clk = ~clk;

    // Generous ceiling: the whole run needs well under two thousand cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fail_count++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        if (fail_count == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic bus_wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        model[a] = (d & mask[a]) | (model[a] & ~mask[a]);
    endtask

    task automatic bus_rd_check(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1 check("read data", model[a], rdata);
    endtask

    task automatic check_outputs();
        repeat (2) @(posedge clk);
        #1;
        check("tx delay", 16'(model[8'h86][7:4]), 16'(tx_dly));
        check("rx delay", 16'(model[8'h86][3:0]), 16'(rx_dly));
        check("eq word", model[8'h8a], eq);
        check("fine gain", {model[8'ha1][11:8], model[8'ha1][3:0], model[8'ha0][11:8], model[8'ha0][3:0]}, gain);
        check("swing a", 16'(model[8'ha2][5] ? model[8'ha2][4:0] : 5'h10), 16'(sw_a));
        check("swing b", 16'(model[8'ha2][13] ? model[8'ha2][12:8] : 5'h10), 16'(sw_b));
    endtask

    task automatic do_reset(input logic v);
        variant <= v;
        rst_n   <= 1'b0;
        repeat (5) @(posedge clk);
        rst_n   <= 1'b1;
        repeat (4) @(posedge clk);
        foreach (model[i]) model[i] = 16'h0000;
        model[8'h7b] = 16'h05dc;
        model[8'h7c] = 16'h007d;
        model[8'h86] = v ? {8'h00, stx, srx} : 16'h0077;
        model[8'ha0] = {4'h0, trim[7:4], 4'h0, trim[3:0]};
        model[8'ha1] = {4'h0, trim[15:12], 4'h0, trim[11:8]};
        model[8'ha2] = 16'h0810;
    endtask

    initial
    begin
        trim <= 16'($random(seed));
        foreach (mask[i]) mask[i] = 16'h0000;
        mask[8'h7b] = 16'hffff;
        mask[8'h7c] = 16'h00ff;
        mask[8'h86] = 16'h00ff;
        mask[8'h8a] = 16'hffff;
        mask[8'ha0] = 16'h0f0f;
        mask[8'ha1] = 16'h0f0f;
        mask[8'ha2] = 16'h3f3f;
        mask[8'hf0] = 16'h0001;
        do_reset(1'b0);
        foreach (ofs[i]) bus_rd_check(ofs[i]);
        check_outputs();
        repeat (3)
        begin
            foreach (ofs[i]) bus_wr(ofs[i], 16'($random(seed)));
            foreach (ofs[i]) bus_rd_check(ofs[i]);
            check_outputs();
        end
        bus_wr(8'h55, 16'hffff);
        bus_rd_check(8'h55);
        bus_wr(8'h8a, 16'h010f);
        bus_wr(8'ha2, 16'h3f3f);
        check_outputs();
        bus_wr(8'ha2, 16'h1f1f);
        check_outputs();
        // Short packet and two-unit gap keep the stream check brief
        bus_wr(8'h7b, 16'h0002);
        bus_wr(8'h7c, 16'h0002);
        repeat (14) q.push_back(5);
        q.push_back(13);
        for (int k = 0; k < 2; k++)
        begin
            q.push_back(k & 15);
            q.push_back((k >> 4) & 15);
        end
        bus_wr(8'hf0, 16'h0001);
        for (int i = 0; i < 50 && nvalid !== 1'b1; i++)
            @(posedge clk) #1;
        foreach (q[i])
        begin
            check("stream nibble", 16'(q[i]), 16'(nib));
            check("stream valid", 16'h0001, 16'(nvalid));
            @(posedge clk) #1;
        end
        repeat (16)
        begin
            check("gap idle", 16'h0000, 16'(nvalid));
            @(posedge clk) #1;
        end
        check("next packet", 16'h0015, {11'h0, nvalid, nib});
        // One packet finished, the second under way: count 1, generator busy
        model[8'hf1] = 16'h0101;
        bus_rd_check(8'hf1);
        bus_wr(8'hf0, 16'h0000);
        do_reset(1'b1);
        bus_rd_check(8'h86);
        check_outputs();
        tally_and_finish();
    end
endmodule // testbench
`default_nettype wire
